/* rtl/flash_status_host.sv */
// Host controller that writes flash commands and polls status bits
// Notes on behaviour
// [R01] Busy bit toggles per read while programming
// [R02] Busy bit valid after last write rise
// [R03] Protected program: toggles about 1 us
// [R04] Busy bit toggles during erase, stops after
// [R05] All protected erase: toggles about 100 us
// [R06] Erase skips protected selected sectors
// [R07] Sector bit toggles on reads in erasing sectors
// [R08] Fail bit set on pulse limit overrun
// [R09] Host trusts fail bit only while busy
// [R10] Fail bit also on programming 0 to 1
// [R11] Host writes reset command after failure
// [R12] Window bit 0 until erase starts, then 1
// [R13] Extra sectors accepted only while window 0
// [R14] Host checks window before and after sector
// [R15] Writes ignored below lockout threshold
// [R16] Glitches under 5 ns start no write
// [R17] Write needs CS, WE low, OE high
// [R18] Power-up strobe levels give no command
// [R19] Array changes need full command sequence
// [R20] Poll bit inverse while busy, true when done
// [R21] Ready/busy pin low while algorithm runs
// [R22] Erase acceptance window lasts 50 us
// [R23] Idle reads return plain array data
`timescale 1ns/1ps
module flash_status_host
  import flash_host_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CE,
  input wire logic [REG_AW-1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [DATA_W-1:0] REG_RDATA,
  output logic [ADDR_W-1:0] FL_ADDR,
  input wire logic [DATA_W-1:0] FL_DQ_IN,
  output logic [DATA_W-1:0] FL_DQ_OUT,
  output logic FL_DQ_OE,
  output logic FL_CS_N,
  output logic FL_WE_N,
  output logic FL_OE_N,
  input wire logic FL_READY_BUSY_N
);
  typedef enum logic [2:0] {
    H_IDLE, H_WRITE, H_READ, H_POLL1, H_POLL2, H_WAIT, H_RESET
  } host_st_t;

  cyc_if cyc ();

  host_st_t st_q, st_d;
  logic [ADDR_W-1:0] addr_reg_q, addr_reg_d;
  logic [DATA_W-1:0] wdata_reg_q, wdata_reg_d;
  logic [DATA_W-1:0] rdata_reg_q, rdata_reg_d;
  logic [DATA_W-1:0] first_q, first_d;
  logic toggle_q, toggle_d, fail_q, fail_d, win_q, win_d;
  logic sect_q, sect_d, done_q, done_d;
  logic [DATA_W-1:0] reg_rdata_d;
  logic start_d, start_q;
  bus_op_t op_d, op_q;
  logic [2:0] rb_sync_q;
  logic rb_stable_q, rb_stable_d;
  logic auto_q;
  logic auto_d;
  logic refused_q;
  logic refused_d;
  logic [7:0] polls_q;
  logic [7:0] polls_d;
  logic stuck_q;
  logic stuck_d;
  logic lost_q;
  logic lost_d;

  assign cyc.start = start_q;
  assign cyc.op = op_q;
  assign cyc.addr = addr_reg_q;
  // Reset command after a failure replaces the software write data
  assign cyc.wdata = (st_q == H_RESET) ? CMD_RESET : wdata_reg_q; // [R11]

  flash_cycle_seq u_seq (
    .clk(CLK_SYS),
    .rst(RST),
    .ce(CE),
    .req(cyc),
    .dq_in(FL_DQ_IN),
    .addr_q(FL_ADDR),
    .dq_out_q(FL_DQ_OUT),
    .dq_oe_q(FL_DQ_OE),
    .cs_n_q(FL_CS_N),
    .we_n_q(FL_WE_N),
    .oe_n_q(FL_OE_N)
  );

  // Ready/busy pin: three stages, accepted when last two agree
  always_comb begin
    rb_stable_d = rb_stable_q;
    if (rb_sync_q[1] == rb_sync_q[2]) begin
      rb_stable_d = rb_sync_q[2]; // [R21]
    end
  end

  always_comb begin
    st_d = st_q;
    addr_reg_d = addr_reg_q;
    wdata_reg_d = wdata_reg_q;
    rdata_reg_d = rdata_reg_q;
    first_d = first_q;
    toggle_d = toggle_q;
    fail_d = fail_q;
    win_d = win_q;
    sect_d = sect_q;
    done_d = done_q;
    start_d = 1'b0;
    op_d = op_q;
    auto_d = auto_q;
    polls_d = polls_q;
    refused_d = refused_q;
    stuck_d = stuck_q;
    lost_d = lost_q;
    if (REG_WR && (st_q == H_IDLE)) begin
      if (REG_ADDR == OFF_ADDR) begin
        addr_reg_d = ADDR_W'(REG_WDATA);
      end
      if (REG_ADDR == OFF_WDATA) begin
        wdata_reg_d = REG_WDATA;
      end
    end
    // Writes that land mid-command are dropped; flag them for software
    if (REG_WR && (st_q != H_IDLE)) begin
      if ((REG_ADDR == OFF_CTRL) || (REG_ADDR == OFF_ADDR) ||
          (REG_ADDR == OFF_WDATA)) begin
        refused_d = 1'b1;
      end
    end
    unique case (st_q)
      H_IDLE: begin
        if (REG_WR && (REG_ADDR == OFF_CTRL)) begin
          done_d = 1'b0;
          refused_d = 1'b0;
          auto_d = 1'b0;
          polls_d = 8'h00;
          stuck_d = 1'b0;
          // Each write is one bus cycle; software builds full sequences
          if (REG_WDATA[CTRL_GO_WR]) begin
            op_d = OP_WRITE; // [R19] [R11]
            start_d = 1'b1;
            st_d = H_WRITE;
          end else if (REG_WDATA[CTRL_GO_RD]) begin
            op_d = OP_READ;
            start_d = 1'b1;
            st_d = H_READ;
          end else if (REG_WDATA[CTRL_GO_POLL]) begin
            op_d = OP_READ; // [R14]
            start_d = 1'b1;
            st_d = H_POLL1;
          end else if (REG_WDATA[CTRL_GO_AUTO]) begin
            // Poll pairs repeat until the busy bit settles, the fail bit sets or POLL_MAX is hit
            op_d = OP_READ; // [R14]
            auto_d = 1'b1;
            start_d = 1'b1;
            st_d = H_POLL1;
          end
        end
      end
      H_WRITE: begin
        if (cyc.done) begin
          done_d = 1'b1;
          st_d = H_IDLE;
        end
      end
      H_READ: begin
        if (cyc.done) begin
          rdata_reg_d = cyc.rdata; // [R23]
          done_d = 1'b1;
          st_d = H_IDLE;
        end
      end
      H_POLL1: begin
        if (cyc.done) begin
          first_d = cyc.rdata;
          st_d = H_WAIT;
        end
      end
      H_WAIT: begin
        start_d = 1'b1;
        st_d = H_POLL2;
      end
      H_POLL2: begin
        if (cyc.done) begin
          rdata_reg_d = cyc.rdata;
          // Two reads compared: a flipped bit means still running
          toggle_d = first_q[BIT_BUSY] ^ cyc.rdata[BIT_BUSY]; // [R01] [R04]
          sect_d = first_q[BIT_SECT] ^ cyc.rdata[BIT_SECT]; // [R07]
          // Fail counts only while the algorithm still toggles
          fail_d = toggle_d & cyc.rdata[BIT_FAIL]; // [R09] [R08] [R10]
          win_d = cyc.rdata[BIT_WIN]; // [R12] [R13] [R14]
          // Window bit rising between the two reads: sector may be lost
          lost_d = !first_q[BIT_WIN] & cyc.rdata[BIT_WIN]; // [R14]
          polls_d = polls_q + 8'h01;
          if (auto_q && fail_d) begin
            // Failed algorithm: send the reset command ourselves
            op_d = OP_WRITE; // [R11]
            start_d = 1'b1;
            st_d = H_RESET;
          end else if (auto_q && toggle_d && (polls_q != POLL_MAX)) begin
            // Second read serves as the first of the next pair
            first_d = cyc.rdata;
            st_d = H_WAIT;
          end else begin
            // Cap reached while the device still toggles
            if (auto_q && toggle_d) begin
              stuck_d = 1'b1;
            end
            done_d = 1'b1;
            st_d = H_IDLE;
          end
        end
      end
      H_RESET: begin
        // Device is back in read mode once this write lands
        if (cyc.done) begin
          done_d = 1'b1;
          st_d = H_IDLE;
        end
      end
      default: st_d = H_IDLE;
    endcase
  end

  always_comb begin
    reg_rdata_d = ZERO_W;
    if (REG_RD) begin
      unique case (REG_ADDR)
        OFF_ADDR: reg_rdata_d = DATA_W'(addr_reg_q);
        OFF_WDATA: reg_rdata_d = wdata_reg_q;
        OFF_RDATA: reg_rdata_d = rdata_reg_q;
        // Toggle pairs read since the last accepted CTRL write
        OFF_POLLS: reg_rdata_d = DATA_W'(polls_q);
        OFF_STAT: begin
          reg_rdata_d[ST_BUSY] = (st_q != H_IDLE);
          reg_rdata_d[ST_TOGGLE] = toggle_q;
          reg_rdata_d[ST_FAIL] = fail_q;
          reg_rdata_d[ST_WIN] = win_q;
          reg_rdata_d[ST_SECT] = sect_q;
          reg_rdata_d[ST_RDY] = rb_stable_q; // [R21]
          reg_rdata_d[ST_DONE] = done_q;
          reg_rdata_d[ST_REFUSED] = refused_q;
          reg_rdata_d[ST_STUCK] = stuck_q;
          reg_rdata_d[ST_LOST] = lost_q;
        end
        default: reg_rdata_d = ZERO_W;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      st_q <= H_IDLE;
      addr_reg_q <= '0;
      wdata_reg_q <= ZERO_W;
      rdata_reg_q <= ZERO_W;
      first_q <= ZERO_W;
      toggle_q <= 1'b0;
      fail_q <= 1'b0;
      win_q <= 1'b0;
      sect_q <= 1'b0;
      done_q <= 1'b0;
      start_q <= 1'b0;
      op_q <= OP_WRITE;
      rb_sync_q <= 3'h7;
      rb_stable_q <= 1'b1;
      REG_RDATA <= ZERO_W;
      auto_q <= 1'b0;
      polls_q <= 8'h00;
      refused_q <= 1'b0;
      stuck_q <= 1'b0;
      lost_q <= 1'b0;
    end else if (CE) begin
      st_q <= st_d;
      addr_reg_q <= addr_reg_d;
      wdata_reg_q <= wdata_reg_d;
      rdata_reg_q <= rdata_reg_d;
      first_q <= first_d;
      toggle_q <= toggle_d;
      fail_q <= fail_d;
      win_q <= win_d;
      sect_q <= sect_d;
      done_q <= done_d;
      start_q <= start_d;
      op_q <= op_d;
      rb_sync_q <= {rb_sync_q[1:0], FL_READY_BUSY_N};
      rb_stable_q <= rb_stable_d;
      REG_RDATA <= reg_rdata_d;
      auto_q <= auto_d;
      polls_q <= polls_d;
      refused_q <= refused_d;
      stuck_q <= stuck_d;
      lost_q <= lost_d;
    end
  end
endmodule : flash_status_host

/* shared/flash_host_pkg.sv */
// Constants and types shared by the flash status host controller
package flash_host_pkg;
  localparam int CLK_MHZ = 10;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int REG_AW = 4;
  // Bus timing in ns, converted to clock cycles (least times round up)
  localparam int T_STROBE_NS = 100;
  localparam int T_ACCESS_NS = 120;
  localparam int T_STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int T_ACCESS_CYC = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] STROBE_CYC = 8'(T_STROBE_CYC < 1 ? 1 : T_STROBE_CYC);
  localparam logic [7:0] ACCESS_CYC = 8'(T_ACCESS_CYC < 1 ? 1 : T_ACCESS_CYC);
  localparam logic [7:0] GAP_CYC = 8'h01;
  // Status bit positions on the flash data bus
  localparam int BIT_POLL = 7;
  localparam int BIT_BUSY = 6;
  localparam int BIT_FAIL = 5;
  localparam int BIT_WIN = 3;
  localparam int BIT_SECT = 2;
  // Host register offsets
  localparam logic [REG_AW-1:0] OFF_CTRL = 4'h0;
  localparam logic [REG_AW-1:0] OFF_ADDR = 4'h1;
  localparam logic [REG_AW-1:0] OFF_WDATA = 4'h2;
  localparam logic [REG_AW-1:0] OFF_RDATA = 4'h3;
  localparam logic [REG_AW-1:0] OFF_STAT = 4'h4;
  // CTRL fields
  localparam int CTRL_GO_WR = 0;
  localparam int CTRL_GO_RD = 1;
  localparam int CTRL_GO_POLL = 2;
  // STAT fields
  localparam int ST_BUSY = 0;
  localparam int ST_TOGGLE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_WIN = 3;
  localparam int ST_SECT = 4;
  localparam int ST_RDY = 5;
  localparam int ST_DONE = 6;
  localparam logic [DATA_W-1:0] ZERO_W = 16'h0000;
  // Automatic poll, refusal and reset command
  localparam int CTRL_GO_AUTO = 3;
  localparam int ST_REFUSED = 7;
  localparam int ST_STUCK = 8;
  localparam int ST_LOST = 9;
  localparam logic [REG_AW-1:0] OFF_POLLS = 4'h5;
  localparam logic [7:0] POLL_MAX = 8'h40;
  localparam logic [DATA_W-1:0] CMD_RESET = 16'h00F0;
  typedef enum logic [1:0] {OP_WRITE, OP_READ} bus_op_t;
endpackage : flash_host_pkg

/* shared/cyc_if.sv */
// Request and answer bundle between the controller and its pin sequencer
`timescale 1ns/1ps
interface cyc_if;
  import flash_host_pkg::*;
  logic start;
  flash_host_pkg::bus_op_t op;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic done;
  logic [DATA_W-1:0] rdata;
  modport ctl (output start, op, addr, wdata, input done, rdata);
  modport seq (input start, op, addr, wdata, output done, rdata);
endinterface : cyc_if

/* rtl/flash_cycle_seq.sv */
// Flash pin sequencer: one write or read cycle on the parallel bus
`timescale 1ns/1ps
module flash_cycle_seq
  import flash_host_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  cyc_if.seq req,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [ADDR_W-1:0] addr_q,
  output logic [DATA_W-1:0] dq_out_q,
  output logic dq_oe_q,
  output logic cs_n_q,
  output logic we_n_q,
  output logic oe_n_q
);
  typedef enum logic [1:0] {S_IDLE, S_SETUP, S_PULSE, S_GAP} seq_st_t;
  seq_st_t st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  bus_op_t op_q, op_d;
  logic [ADDR_W-1:0] addr_d;
  logic [DATA_W-1:0] dq_out_d, rdata_q, rdata_d;
  logic dq_oe_d, cs_n_d, we_n_d, oe_n_d, done_q, done_d;

  assign req.done = done_q;
  assign req.rdata = rdata_q;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    op_d = op_q;
    addr_d = addr_q;
    dq_out_d = dq_out_q;
    dq_oe_d = dq_oe_q;
    cs_n_d = cs_n_q;
    we_n_d = we_n_q;
    oe_n_d = oe_n_q;
    rdata_d = rdata_q;
    done_d = 1'b0;
    unique case (st_q)
      S_IDLE: begin
        if (req.start) begin
          op_d = req.op;
          addr_d = req.addr;
          dq_out_d = req.wdata;
          dq_oe_d = (req.op == OP_WRITE);
          cs_n_d = 1'b0;
          st_d = S_SETUP;
        end
      end
      S_SETUP: begin
        // Write only with OE high, CS and WE low; pulse far above 5 ns
        if (op_q == OP_WRITE) begin
          oe_n_d = 1'b1; // [R17] [R16]
          we_n_d = 1'b0; // [R17]
          cnt_d = STROBE_CYC;
        end else begin
          we_n_d = 1'b1; // [R17]
          oe_n_d = 1'b0; // [R02]
          cnt_d = ACCESS_CYC;
        end
        st_d = S_PULSE;
      end
      S_PULSE: begin
        if (cnt_q > 8'h01) begin
          cnt_d = cnt_q - 8'h01;
        end else begin
          if (op_q == OP_READ) begin
            rdata_d = dq_in;
          end
          we_n_d = 1'b1;
          oe_n_d = 1'b1;
          cs_n_d = 1'b1;
          cnt_d = GAP_CYC;
          st_d = S_GAP;
        end
      end
      S_GAP: begin
        dq_oe_d = 1'b0;
        if (cnt_q > 8'h01) begin
          cnt_d = cnt_q - 8'h01;
        end else begin
          done_d = 1'b1;
          st_d = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= S_IDLE;
      cnt_q <= 8'h00;
      op_q <= OP_WRITE;
      addr_q <= '0;
      dq_out_q <= ZERO_W;
      dq_oe_q <= 1'b0;
      cs_n_q <= 1'b1;
      we_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      rdata_q <= ZERO_W;
      done_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      op_q <= op_d;
      addr_q <= addr_d;
      dq_out_q <= dq_out_d;
      dq_oe_q <= dq_oe_d;
      cs_n_q <= cs_n_d;
      we_n_q <= we_n_d;
      oe_n_q <= oe_n_d;
      rdata_q <= rdata_d;
      done_q <= done_d;
    end
  end
endmodule : flash_cycle_seq

/* bench/flash_status_host_chk.sv */
// Checker for the flash host pin and register timing
`timescale 1ns/1ps
module flash_status_host_chk (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic REG_RD,
  input wire logic [15:0] REG_RDATA,
  input wire logic FL_DQ_OE,
  input wire logic FL_CS_N,
  input wire logic FL_WE_N,
  input wire logic FL_OE_N
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  a_no_we_oe: assert property (!(!FL_WE_N && !FL_OE_N))
    else $error("write and output strobe low together");
  a_we_cs_first: assert property ($fell(FL_WE_N) |-> $past(FL_CS_N) == 1'b0)
    else $error("write strobe fell without chip select");
  a_we_one_cyc: assert property ($fell(FL_WE_N) |=> FL_WE_N)
    else $error("write strobe not one cycle");
  a_oe_two_cyc: assert property ($fell(FL_OE_N) |=> !FL_OE_N ##1 FL_OE_N)
    else $error("output strobe not two cycles");
  a_oe_with_cs: assert property (!FL_OE_N |-> !FL_CS_N && !FL_DQ_OE)
    else $error("read without chip select or with drive");
  a_we_data_on: assert property (!FL_WE_N |-> FL_DQ_OE && !FL_CS_N)
    else $error("write strobe without data drive");
  a_dq_release: assert property ($rose(FL_WE_N) |-> FL_DQ_OE ##1 !FL_DQ_OE)
    else $error("data drive not released after write");
  a_rdata_zero: assert property (!$past(REG_RD) |-> REG_RDATA == 16'h0000)
    else $error("read data outside its cycle");
  a_reset_idle: assert property ($fell(RST) |->
    FL_CS_N && FL_WE_N && FL_OE_N && !FL_DQ_OE)
    else $error("strobes not idle after reset");
  c_write: cover property ($fell(FL_WE_N));
  c_read: cover property ($fell(FL_OE_N));
  c_rdata: cover property ($past(REG_RD) && REG_RDATA != 16'h0000);
endmodule : flash_status_host_chk
bind flash_status_host flash_status_host_chk flash_status_host_chk_inst (
  .CLK_SYS(CLK_SYS), .RST(RST), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .FL_DQ_OE(FL_DQ_OE), .FL_CS_N(FL_CS_N), .FL_WE_N(FL_WE_N),
  .FL_OE_N(FL_OE_N));

/* bench/flash_dev_model.sv */
// Behavioural flash device answering program commands and status reads
`timescale 1ns/1ps
module flash_dev_model (
  input wire logic [19:0] addr,
  input wire logic [15:0] dq_w,
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic oe_n,
  output logic [15:0] dq_r,
  output logic drive,
  output logic busy
);
  logic [15:0] mem [0:255];
  logic [15:0] last;
  logic [1:0] seq;
  logic tog, fail, w_arm, r_arm;
  int left;
  initial begin
    foreach (mem[k]) mem[k] = 16'hFFFF;
    last = 16'h0000;
    seq = 2'h0;
    tog = 1'b0;
    fail = 1'b0;
    w_arm = 1'b0;
    r_arm = 1'b0;
    left = 0;
  end
  assign drive = !cs_n && !oe_n;
  assign busy = left > 0;
  assign dq_r = busy ? {last[15:8], ~last[7], tog, fail, last[4:0]} :
    mem[addr[7:0]];
  always @(negedge we_n) w_arm = !cs_n && oe_n;
  always @(negedge oe_n) r_arm = !cs_n;
  always @(posedge we_n) if (w_arm) begin
    w_arm = 1'b0;
    if (busy) begin
      if (dq_w == 16'h00F0) begin
        left = 0;
        fail = 1'b0;
      end
    end else if (seq == 2'h3) begin
      fail = |(dq_w & ~mem[addr[7:0]]);
      mem[addr[7:0]] = mem[addr[7:0]] & dq_w;
      last = dq_w;
      left = 4;
      seq = 2'h0;
    end else if (dq_w == {8'h00, seq == 2'h0 ? 8'hAA :
        seq == 2'h1 ? 8'h55 : 8'hA0}) seq = seq + 2'h1;
    else seq = 2'h0;
  end
  always @(posedge oe_n) if (r_arm && busy) begin
    tog = ~tog;
    if (!fail) left = left - 1;
  end
endmodule : flash_dev_model

/* bench/test_flash_status_host.sv */
// Self-checking bench for the flash status host controller
`timescale 1ns/1ps
`define CHECK(n, e, s) begin checks++; if ((s) !== (e)) begin \
  mismatches++; $display("wrong value %s exp %h seen %h", n, e, s); end end
module test_flash_status_host import flash_host_pkg::*;;
  logic CLK_SYS = 1'b0;
  logic RST = 1'b1;
  logic [REG_AW-1:0] REG_ADDR = 4'h0;
  logic [DATA_W-1:0] REG_WDATA = 16'h0000;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic CE = 1'b1;
  logic [DATA_W-1:0] REG_RDATA, FL_DQ_OUT, dev_q, v, s, d, a;
  logic [ADDR_W-1:0] FL_ADDR;
  logic FL_DQ_OE, FL_CS_N, FL_WE_N, FL_OE_N, dev_drive, dev_busy;
  int mismatches = 0;
  int checks = 0;
  int seed, i;
  wire [DATA_W-1:0] dq_in = dev_drive ? dev_q : FL_DQ_OE ? FL_DQ_OUT :
    16'hA5A5 ^ {16{CLK_SYS}};
  always #50 CLK_SYS = ~CLK_SYS;
  flash_status_host flash_status_host_inst (.CLK_SYS(CLK_SYS), .RST(RST),
    .CE(CE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .FL_ADDR(FL_ADDR),
    .FL_DQ_IN(dq_in), .FL_DQ_OUT(FL_DQ_OUT), .FL_DQ_OE(FL_DQ_OE),
    .FL_CS_N(FL_CS_N), .FL_WE_N(FL_WE_N), .FL_OE_N(FL_OE_N),
    .FL_READY_BUSY_N(!dev_busy));
  flash_dev_model flash_dev_model_inst (.addr(FL_ADDR), .dq_w(FL_DQ_OUT),
    .cs_n(FL_CS_N), .we_n(FL_WE_N), .oe_n(FL_OE_N), .dq_r(dev_q),
    .drive(dev_drive), .busy(dev_busy));
  function automatic logic [15:0] exp_word(input logic [15:0] o, n);
    return o & n;
  endfunction : exp_word
  task automatic reg_wr(input logic [3:0] ra, input logic [15:0] wd);
    @(posedge CLK_SYS);
    REG_ADDR <= ra;
    REG_WDATA <= wd;
    REG_WR <= 1'b1;
    @(posedge CLK_SYS);
    REG_WR <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] ra, output logic [15:0] rd);
    @(posedge CLK_SYS);
    REG_ADDR <= ra;
    REG_RD <= 1'b1;
    @(posedge CLK_SYS);
    REG_RD <= 1'b0;
    #1 rd = REG_RDATA;
  endtask : reg_rd
  task automatic run(input logic [15:0] op, output logic [15:0] st);
    int n;
    reg_wr(OFF_CTRL, op);
    repeat (2) @(posedge CLK_SYS);
    n = 0;
    st = 16'h0001;
    while (st[ST_BUSY] !== 1'b0 && n < 40) begin
      reg_rd(OFF_STAT, st);
      n++;
    end
    `CHECK("busy", 1'b0, st[ST_BUSY])
  endtask : run
  task automatic flash_wr(input logic [15:0] fa, fd);
    reg_wr(OFF_ADDR, fa);
    reg_wr(OFF_WDATA, fd);
    run(16'h0001, s);
  endtask : flash_wr
  task automatic flash_rd(input logic [15:0] fa, output logic [15:0] fd);
    reg_wr(OFF_ADDR, fa);
    run(16'h0002, s);
    reg_rd(OFF_RDATA, fd);
  endtask : flash_rd
  task automatic prog(input logic [15:0] fa, fd);
    flash_wr(fa, 16'h00AA);
    flash_wr(fa, 16'h0055);
    flash_wr(fa, 16'h00A0);
    flash_wr(fa, fd);
  endtask : prog
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  initial begin
    #3000000;
    mismatches++;
    complete_run();
  end
  initial begin
    seed = 72531;
    repeat (4) @(posedge CLK_SYS);
    RST <= 1'b0;
    reg_rd(4'hF, v);
    `CHECK("unmapped", 16'h0000, v)
    for (i = 0; i < 3; i++) begin
      a = 16'((i << 4) | ($random(seed) & 15));
      d = (i == 0) ? 16'h0000 : 16'($random(seed));
      prog(a, d);
      flash_rd(a, v);
      `CHECK("poll bit", ~d[7], v[7])
      run(16'h0004, s);
      `CHECK("toggled", 1'b1, s[ST_TOGGLE])
      `CHECK("ready pin", 1'b0, s[ST_RDY])
      run(16'h0004, s);
      run(16'h0004, s);
      `CHECK("settled", 1'b0, s[ST_TOGGLE])
      `CHECK("ready", 1'b1, s[ST_RDY])
      flash_rd(a, v);
      `CHECK("array", exp_word(16'hFFFF, d), v)
      $display("test program %0d done", i);
    end
    a = 16'h0000 | (a & 16'h000F);
    prog(16'h0000 | (a & 16'h0000), 16'h0000);
    run(16'h0004, s);
    run(16'h0004, s);
    run(16'h0004, s);
    prog(16'h0000, 16'h0001);
    run(16'h0004, s);
    `CHECK("fail", 1'b1, s[ST_FAIL])
    run(16'h0004, s);
    `CHECK("still busy", 1'b1, s[ST_TOGGLE])
    flash_wr(16'h0000, 16'h00F0);
    run(16'h0004, s);
    `CHECK("fail cleared", 1'b0, s[ST_FAIL])
    `CHECK("no toggle", 1'b0, s[ST_TOGGLE])
    $display("test failure done");
    prog(16'h0000, 16'h0001);
    run(16'h0008, s);
    `CHECK("auto fail", 1'b1, s[ST_FAIL])
    reg_rd(OFF_POLLS, v);
    `CHECK("auto polls", 16'h0001, v)
    run(16'h0004, s);
    `CHECK("auto reset", 1'b0, s[ST_TOGGLE])
    d = 16'($random(seed));
    prog(16'h0040, d);
    run(16'h0008, s);
    `CHECK("auto settled", 1'b0, s[ST_TOGGLE])
    flash_rd(16'h0040, v);
    `CHECK("auto array", exp_word(16'hFFFF, d), v)
    $display("test auto poll done");
    reg_wr(OFF_ADDR, 16'h0012);
    @(posedge CLK_SYS) CE <= 1'b0;
    reg_wr(OFF_ADDR, 16'h0034);
    CE <= 1'b1;
    reg_rd(OFF_ADDR, v);
    `CHECK("frozen", 16'h0012, v)
    reg_wr(OFF_CTRL, 16'h0002);
    reg_wr(OFF_ADDR, 16'h0056);
    repeat (20) @(posedge CLK_SYS);
    reg_rd(OFF_STAT, s);
    `CHECK("refused", 1'b1, s[ST_REFUSED])
    reg_rd(OFF_ADDR, v);
    `CHECK("kept addr", 16'h0012, v)
    $display("test freeze and refuse done");
    flash_wr(16'h00F3, 16'h0000);
    flash_rd(16'h00F3, v);
    `CHECK("lone write", 16'hFFFF, v)
    $display("test lone write done");
    complete_run();
  end
endmodule : test_flash_status_host
